/* File: hdl/pefb_change_det.sv */
/*
 * Generic change detector: one pulse per bit whose input differs from the
 * previous cycle. Assumes inputs are already synchronous to clk.
 */
`timescale 1ns/100ps
module pefb_change_det #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] src,
   output logic      [WIDTH-1:0] chg
);

   logic [WIDTH-1:0] prev_r;
   logic             primed_r;

   // Previous value; no pulse in the first cycle after reset, since the
   // history is not yet known and a spurious flag would fire
   always_ff @(posedge clk) begin
      prev_r <= src;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         primed_r <= 1'b0;
      end else begin
         primed_r <= 1'b1;
      end
   end

   assign chg = primed_r ? (src ^ prev_r) : '0;

endmodule

/* File: hdl/pefb_flag_bank.sv */
/*
 * Latched change-event flags of the power-management device: three flag
 * registers, their masks, the battery and converter status register and
 * the interrupt output. Assumes a register port driven by the serial host
 * interface, one access per cycle, sources synchronous to clk.
 */
// Summary of operation
// - Status bit 6 reads 1 when battery is at or above target.
// - Battery bit valid only with input present, 01 pair, charger on, no limiting.
// - Status bit 5 reads 1 while the buck-boost converter is faulted.
// - First flag register bit 7 sets on any thermistor zone change.
// - First flag register bit 6 sets on any charger state change.
// - First flag register bit 5 sets on input current limiting change.
// - Bit 2 sets on temperature-zone shutdown change.
// - Bit 1 sets on temperature-zone regulation change.
// - Second register bits 4, 3 set on regulator 2, 1 undervoltage change.
// - Second register bits 1, 0 set on load switch 1, 2 timeout change.
// - Third register bits set on change of matching companion status bit.
// - Mask bit 0 blocks its flag from the interrupt, 1 passes it.
`timescale 1ns/100ps
module pefb_flag_bank (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire pefb_pkg::pefb_src_t src,
   input  wire logic               battery_at_target,
   input  wire logic               bb_converter_fault,
   input  wire logic               charger_input,
   input  wire logic               charger_enabled,
   input  wire logic [7:0]         reg_addr,
   input  wire logic               reg_wr,
   input  wire logic [7:0]         reg_wdata,
   input  wire logic               reg_rd,
   output logic      [7:0]         reg_rdata,
   output logic                    irq
);

   // ---------------------------------------------------------------------
   // Change detection
   // ---------------------------------------------------------------------
   logic [pefb_pkg::SRC_W-1:0] chg_bits;
   pefb_pkg::pefb_src_t        chg;
   logic [7:0]                 ev [pefb_pkg::NUM_BANKS];
   logic [7:0]                 flag_r [pefb_pkg::NUM_BANKS];
   logic [7:0]                 mask_r [pefb_pkg::NUM_BANKS];
   logic [7:0]                 reg_rdata_r;
   logic                       bat_valid;

   pefb_change_det #(
      .WIDTH (pefb_pkg::SRC_W)
   ) u_det (
      .clk (clk),
      .rst (rst),
      .src (src),
      .chg (chg_bits)
   );

   assign chg = pefb_pkg::pefb_src_t'(chg_bits);

   // Events grouped per flag register; zone and state fields collapse to one flag each, companion bits map one to one
   assign ev[0] = {|chg.thermistor_zone,
                   |chg.charger_state,
                   chg.current_limiting,
                   chg.input_overvoltage,
                   chg.input_valid,
                   chg.temp_zone_shutdown,
                   chg.temp_zone_regulation,
                   chg.charge_timer_timeout};
   assign ev[1] = {chg.charger_overheat, 1'b0, chg.linear_switch_overheat,
                   chg.linear_reg2_undervoltage,
                   chg.linear_reg1_undervoltage, 1'b0,
                   chg.load_switch1_timeout,
                   chg.load_switch2_timeout};
   assign ev[2] = chg.companion;

   // ---------------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   function automatic logic [7:0] flag_ofs(input int i);
      flag_ofs = (i == 0) ? pefb_pkg::FLAG0_OFS :
                 (i == 1) ? pefb_pkg::FLAG1_OFS : pefb_pkg::FLAG2_OFS;
   endfunction

   function automatic logic [7:0] mask_ofs(input int i);
      mask_ofs = (i == 0) ? pefb_pkg::MASK0_OFS :
                 (i == 1) ? pefb_pkg::MASK1_OFS : pefb_pkg::MASK2_OFS;
   endfunction

   // ---------------------------------------------------------------------
   // Flags and masks
   // ---------------------------------------------------------------------
   // Write 1 clears; a new event in the clearing cycle wins so none is lost
   generate
      for (genvar i = 0; i < pefb_pkg::NUM_BANKS; i++) begin : g_bank
         logic [7:0] clr;
         logic [7:0] used;
         assign used = (i == 1) ? pefb_pkg::FLAG1_USED : 8'hff;
         assign clr  = (reg_wr && hit(reg_addr, flag_ofs(i))) ? reg_wdata : 8'h00;

         always_ff @(posedge clk) begin
            if (rst) begin
               flag_r[i] <= pefb_pkg::FLAG_RST;
            end else begin
               flag_r[i] <= ((flag_r[i] & ~clr) | ev[i]) & used;
            end
         end

         always_ff @(posedge clk) begin
            if (rst) begin
               mask_r[i] <= pefb_pkg::MASK_RST;
            end else if (reg_wr && hit(reg_addr, mask_ofs(i))) begin
               mask_r[i] <= reg_wdata;
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------------
   // Status, read data and interrupt
   // ---------------------------------------------------------------------
   // Battery bit is meaningless off-charge, so it reads 0 unless qualified
   assign bat_valid = charger_input && !src.input_overvoltage && src.input_valid
                      && charger_enabled
                      && !src.companion[pefb_pkg::SYS_LIM_BIT];

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata_r <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata_r <= 8'h00;  // Unmapped offsets read zero
         if (hit(reg_addr, pefb_pkg::STATUS_OFS)) begin
            reg_rdata_r[pefb_pkg::BAT_TGT_BIT]  <= battery_at_target && bat_valid;
            reg_rdata_r[pefb_pkg::BB_FAULT_BIT] <= bb_converter_fault;
         end
         for (int i = 0; i < pefb_pkg::NUM_BANKS; i++) begin
            if (hit(reg_addr, flag_ofs(i))) begin
               reg_rdata_r <= flag_r[i];
            end
            if (hit(reg_addr, mask_ofs(i))) begin
               reg_rdata_r <= mask_r[i];
            end
         end
      end
   end

   assign reg_rdata = reg_rdata_r;

   // Level output, an OR of flops, so it follows a clear by one cycle
   assign irq = |(flag_r[0] & mask_r[0]) | |(flag_r[1] & mask_r[1])
                | |(flag_r[2] & mask_r[2]);

   // ---------------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------------
   // live_r follows the change detector's arming, so no check expects a flag
   // from the history that is captured in the first cycle after reset
   logic live_r;

   always_ff @(posedge clk) begin
      live_r <= !rst;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_bat_level: assert property (reg_rd && reg_addr == pefb_pkg::STATUS_OFS
      && bat_valid && battery_at_target |=> reg_rdata[6]) else $error("battery bit low");
   chk_bat_valid: assert property (reg_rd && reg_addr == pefb_pkg::STATUS_OFS
      && (!charger_input || !charger_enabled) |=> !reg_rdata[6]) else $error("bat bit unqualified");
   chk_bb_fault: assert property (reg_rd && reg_addr == pefb_pkg::STATUS_OFS
      |=> reg_rdata[5] == $past(bb_converter_fault)) else $error("converter fault bit wrong");
   chk_zone_flag: assert property (live_r && $changed(src.thermistor_zone)
      |=> flag_r[0][7]) else $error("zone change missed");
   chk_state_flag: assert property (live_r && $changed(src.charger_state)
      |=> flag_r[0][6]) else $error("charger state change missed");
   chk_ilim_flag: assert property (live_r && $changed(src.current_limiting)
      |=> flag_r[0][5]) else $error("limit change missed");
   chk_input_flags: assert property (live_r && $changed(src.input_overvoltage)
      |=> flag_r[0][4]) else $error("overvoltage change missed");
   chk_valid_flag: assert property (live_r && $changed(src.input_valid)
      |=> flag_r[0][3]) else $error("input valid change missed");
   chk_shutdown_flag: assert property (live_r && $changed(src.temp_zone_shutdown)
      |=> flag_r[0][2]) else $error("shutdown change missed");
   chk_regul_flag: assert property (live_r && $changed(src.temp_zone_regulation)
      |=> flag_r[0][1]) else $error("regulation change missed");
   chk_timer_flag: assert property (live_r && $changed(src.charge_timer_timeout)
      |=> flag_r[0][0]) else $error("timer change missed");
   chk_uv_flags: assert property (live_r && $changed(src.linear_reg2_undervoltage)
      |=> flag_r[1][4]) else $error("undervoltage change missed");
   chk_lsw_flags: assert property (live_r && $changed(src.load_switch2_timeout)
      |=> flag_r[1][0]) else $error("switch timeout change missed");
   chk_uv1_flag: assert property (live_r && $changed(src.linear_reg1_undervoltage)
      |=> flag_r[1][3]) else $error("regulator one undervoltage change missed");
   chk_lsw1_flag: assert property (live_r && $changed(src.load_switch1_timeout)
      |=> flag_r[1][1]) else $error("switch one timeout change missed");
   chk_comp_flags: assert property (live_r && $changed(src.companion)
      |=> (flag_r[2] & ($past(src.companion) ^ $past(src.companion, 2)))
      == ($past(src.companion) ^ $past(src.companion, 2)))
      else $error("companion change missed");
   chk_mask_gate: assert property (mask_r[0] == 8'h00 && mask_r[1] == 8'h00
      && mask_r[2] == 8'h00 |-> !irq) else $error("masked flag raised interrupt");
   chk_flag_hold: assert property (flag_r[0][7] && !(reg_wr
      && reg_addr == pefb_pkg::FLAG0_OFS && reg_wdata[7]) |=> flag_r[0][7]
      && (!mask_r[0][7] || irq)) else $error("flag lost without clear");
   chk_rsvd_zero: assert property (reg_rd && reg_addr == pefb_pkg::FLAG1_OFS
      |=> reg_rdata[6] == 1'b0 && reg_rdata[2] == 1'b0) else $error("reserved bit set");

   // A passed flag must reach the pin at once, and a clear with no fresh
   // change in the same cycle must drop the flag at the next edge
   chk_mask_pass: assert property (flag_r[0][7] && mask_r[0][7] |-> irq)
      else $error("passed flag missed interrupt");
   chk_clear_drop: assert property (reg_wr && reg_addr == pefb_pkg::FLAG0_OFS
      && reg_wdata[7] && !(live_r && $changed(src.thermistor_zone)) |=> !flag_r[0][7])
      else $error("clear did not drop flag");
   chk_rsvd_write: assert property (reg_wr && reg_addr == pefb_pkg::FLAG1_OFS
      |=> flag_r[1][6] == 1'b0 && flag_r[1][2] == 1'b0) else $error("reserved bit stored");

endmodule

/* File: hdl/pefb_pkg.sv */
/*
 * Shared constants and carriers for the change-event flag bank: register
 * offsets, bit positions, reset values and the packed status source bundle.
 * Assumes the register access port and the status sources share one clock.
 */
package pefb_pkg;

   // --------------------------------------------------------------------
   // Register offsets
   // --------------------------------------------------------------------
   localparam logic [7:0] STATUS_OFS  = 8'h05;  // Battery and converter status
   localparam logic [7:0] FLAG0_OFS   = 8'h06;  // charger_event_flags
   localparam logic [7:0] FLAG1_OFS   = 8'h07;  // regulator_event_flags
   localparam logic [7:0] FLAG2_OFS   = 8'h08;  // converter_event_flags
   localparam logic [7:0] MASK0_OFS   = 8'h0a;  // Mask for charger_event_flags
   localparam logic [7:0] MASK1_OFS   = 8'h0b;  // Mask for regulator_event_flags
   localparam logic [7:0] MASK2_OFS   = 8'h0c;  // Mask for converter_event_flags

   // --------------------------------------------------------------------
   // Field positions and values
   // --------------------------------------------------------------------
   localparam int         BAT_TGT_BIT   = 6;      // Status: battery at target
   localparam int         BB_FAULT_BIT  = 5;      // Status: converter fault
   localparam int         SYS_LIM_BIT   = 5;      // Companion: system limiting
   localparam logic [7:0] FLAG1_USED    = 8'hbb;  // Bits 6 and 2 do not exist
   localparam logic [7:0] MASK_RST      = 8'h00;  // All flags masked at reset
   localparam logic [7:0] FLAG_RST      = 8'h00;
   localparam int         NUM_BANKS     = 3;

   // --------------------------------------------------------------------
   // Status sources watched for change
   // --------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] companion;              // Converter status byte
      logic       load_switch2_timeout;
      logic       load_switch1_timeout;
      logic       linear_reg1_undervoltage;
      logic       linear_reg2_undervoltage;
      logic       linear_switch_overheat;
      logic       charger_overheat;
      logic       charge_timer_timeout;
      logic       temp_zone_regulation;
      logic       temp_zone_shutdown;
      logic       input_valid;
      logic       input_overvoltage;
      logic       current_limiting;
      logic [2:0] charger_state;
      logic [2:0] thermistor_zone;
   } pefb_src_t;

   localparam int SRC_W = $bits(pefb_src_t);

endpackage

/* File: test/pefb_host_model.sv */
/* Host-side model of the flag bank's register port: one-cycle read and
   write strobes. Assumes it shares the flag bank clock. */
`timescale 1ns/100ps
module pefb_host_model (
   input  wire logic       clk,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   // Idle port from time zero
   initial begin
      reg_addr = 8'hff;
      reg_wr = 1'b0;
      reg_wdata = 8'h5a;
      reg_rd = 1'b0;
   end

   // Write; a 1 clears a flag, so software owns clearing
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;  // Released data never shows its last value
   endtask

   // Read; data is registered, so it is taken just after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1 d = reg_rdata;
   endtask
endmodule

/* File: test/pmic_event_flag_bank_test.sv */
/* Self-checking bench for the change-event flag bank. Assumes the host
   model drives the register port; sources are driven here. */
`timescale 1ns/100ps
module pmic_event_flag_bank_test;
   logic                clk;
   logic                rst;
   pefb_pkg::pefb_src_t src;
   logic                battery_at_target;
   logic                bb_converter_fault;
   logic                charger_input;
   logic                charger_enabled;
   logic [7:0]          reg_addr;
   logic                reg_wr;
   logic [7:0]          reg_wdata;
   logic                reg_rd;
   logic [7:0]          reg_rdata;
   logic                irq;
   int                  miscompares = 0;
   int                  n_compared = 0;

   // ----------------------------------------
   // Clock, design and host
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   pefb_flag_bank dut (.clk(clk), .rst(rst), .src(src),
      .battery_at_target(battery_at_target), .bb_converter_fault(bb_converter_fault),
      .charger_input(charger_input), .charger_enabled(charger_enabled),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq));

   pefb_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   // ----------------------------------------
   // Checking helpers
   // ----------------------------------------
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string msg);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t %s: got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Everything reads zero after reset, unmapped place too
   task automatic reset_check;
      logic [7:0] d;
      for (int a = 6; a <= 12; a++) begin
         host.rd(a[7:0], d);
         cmp(d, 8'h00, "reset value");
      end
      host.wr(8'h09, 8'hff);
      host.rd(8'h09, d);
      cmp(d, 8'h00, "unmapped place");
      host.wr(8'h05, 8'hff);
      host.rd(8'h05, d);
      cmp(d, 8'h00, "status ignores writes");
      cmp({7'h0, irq}, 8'h00, "irq after reset");
   endtask

   // Flip sources, then walk the flag through hold, mask and clear
   task automatic ev_check(input logic [25:0] flip, input logic [7:0] ofs,
                           input logic [7:0] exp);
      logic [7:0] d;
      @(posedge clk);
      src <= src ^ flip;
      repeat (2) @(posedge clk);
      host.rd(ofs, d);
      cmp(d, exp, "flag set");
      host.wr(ofs, 8'h00);
      host.rd(ofs, d);
      cmp(d, exp, "flag held on zero write");
      cmp({7'h0, irq}, 8'h00, "irq while masked");
      host.wr(ofs + 8'h04, exp);
      #1 cmp({7'h0, irq}, 8'h01, "irq when passed");
      host.rd(ofs + 8'h04, d);
      cmp(d, exp, "mask read back");
      host.wr(ofs, exp);
      #1 cmp({7'h0, irq}, 8'h00, "irq after clear");
      host.rd(ofs, d);
      cmp(d, 8'h00, "flag cleared");
      host.wr(ofs + 8'h04, 8'h00);
   endtask

   // A change landing in the clearing cycle must keep its flag
   task automatic race_check;
      logic [7:0] d;
      @(posedge clk);
      src.thermistor_zone <= src.thermistor_zone ^ 3'h1;
      repeat (2) @(posedge clk);
      fork
         host.wr(8'h06, 8'h80);
         begin
            @(posedge clk);
            src.thermistor_zone <= src.thermistor_zone ^ 3'h2;
         end
      join
      host.rd(8'h06, d);
      cmp(d, 8'h80, "set wins over clear");
      host.wr(8'h06, 8'h80);
      host.rd(8'h06, d);
      cmp(d, 8'h00, "flag cleared after race");
   endtask

   // Battery bit only with every qualifier met; fault bit unqualified
   task automatic status_check;
      logic [7:0] d;
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         charger_input <= (i != 0);
         src.input_overvoltage <= (i == 1);
         src.input_valid <= (i != 2);
         charger_enabled <= (i != 3);
         src.companion[5] <= (i == 4);
         battery_at_target <= 1'b1;
         host.rd(8'h05, d);
         cmp(d, (i == 5) ? 8'h40 : 8'h00, "battery bit");
      end
      @(posedge clk);
      bb_converter_fault <= 1'b1;
      host.rd(8'h05, d);
      cmp(d, 8'h60, "converter fault bit");
      @(posedge clk);
      battery_at_target <= 1'b0;
      host.rd(8'h05, d);
      cmp(d, 8'h20, "battery below target");
   endtask

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      src = '0;
      battery_at_target = 1'b0;
      bb_converter_fault = 1'b0;
      charger_input = 1'b0;
      charger_enabled = 1'b0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      reset_check();
      ev_check(26'h0000005, 8'h06, 8'h80);
      ev_check(26'h0000028, 8'h06, 8'h40);
      ev_check(26'h0000040, 8'h06, 8'h20);
      ev_check(26'h0000080, 8'h06, 8'h10);
      ev_check(26'h0000100, 8'h06, 8'h08);
      ev_check(26'h0000200, 8'h06, 8'h04);
      ev_check(26'h0000400, 8'h06, 8'h02);
      ev_check(26'h0000800, 8'h06, 8'h01);
      ev_check(26'h000c000, 8'h07, 8'h18);
      ev_check(26'h0030000, 8'h07, 8'h03);
      ev_check(26'h003f000, 8'h07, 8'hbb);
      ev_check(26'h3fc0000, 8'h08, 8'hff);
      race_check();
      status_check();
      stop_test();
   end

   // Whole run is a few hundred cycles; this is far beyond it
   initial begin
      #200000;
      miscompares++;
      stop_test();
   end
endmodule
